/* File: design/csrm_defines.svh */
// Offsets, field positions, reset values and select codes of the
// clock status readback block. Included by the package and the top.
`ifndef CSRM_DEFINES_SVH
`define CSRM_DEFINES_SVH

// Printed register indexes; byte address is four times the index
`define CSRM_IDX_CLK_LOCK 12'h22c
`define CSRM_IDX_HOLD_CAL 12'h22d
`define CSRM_IDX_OUT0_SEL 12'h230

// Clock and lock status fields
`define CSRM_BIT_SECOND_LOOP_REF 7
`define CSRM_BIT_FIRST_LOOP_FB 6
`define CSRM_BIT_OSC_CLOCK 5
`define CSRM_BIT_TEST_REF 4
`define CSRM_BIT_REFERENCE_B 3
`define CSRM_BIT_REFERENCE_A 2
`define CSRM_BIT_SECOND_LOOP_LOCK 1
`define CSRM_BIT_FIRST_LOOP_LOCK 0

// Holdover and calibration status fields
`define CSRM_BIT_HOLDOVER 3
`define CSRM_BIT_REF_B_CHOSEN 2
`define CSRM_BIT_VCO_CAL 0

// Status output 0 select field
`define CSRM_SEL_MSB 5
`define CSRM_SEL_RESET 6'h00
`define CSRM_SEL_RESERVED 6'h0d
`define CSRM_SEL_LAST 6'h17
`define CSRM_SEL_COUNT 24

// Number of status inputs crossing from outside the clock domain
`define CSRM_IN_COUNT 15

`endif

/* File: design/csrm_pkg.sv */
// Types shared by the clock status readback block.
// Assumes the defines header is on the include path.
`include "csrm_defines.svh"
package csrm_pkg;
  typedef logic [`CSRM_SEL_MSB:0] csrm_sel_type;
  typedef logic [31:0] csrm_word_type;
  typedef enum logic [1:0] {
    CSRM_RESP_OKAY = 2'b00,
    CSRM_RESP_SLVERR = 2'b10,
    CSRM_RESP_DECERR = 2'b11
  } csrm_resp_type;
  typedef enum logic [1:0] {
    CSRM_REG_NONE = 2'b00,
    CSRM_REG_CLK_LOCK = 2'b01,
    CSRM_REG_HOLD_CAL = 2'b11,
    CSRM_REG_OUT0_SEL = 2'b10
  } csrm_reg_type;
endpackage : csrm_pkg

/* File: design/csrm_sync.sv */
// Two-stage synchroniser for a group of level inputs.
// Assumes inputs come from pins or other clocks; ce freezes both stages.
`timescale 1ns/1ps
module csrm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Reg;

  // First stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1Reg <= '0;
      syncOut <= '0;
    end else if (ce) begin
      stage1Reg <= asyncIn;
      syncOut <= stage1Reg;
    end
  end
endmodule : csrm_sync

/* File: design/csrm_status_mux.sv */
// Status readback registers and status output 0 selector.
// Assumes an AXI4-Lite master on clk; status inputs are asynchronous.
//
// How it works
// - clock/lock register bits 7..2 clock presence, bits 1..0 loop locks.
// - holdover register bit 3 is one while holdover is active.
// - holdover register bit 2 shows automatic reference choice, one is B.
// - holdover register bit 0 shows calibration busy; others read zero.
// - select register bits 5..0 pick status output 0 source.
// - codes 0..3 give ground, both locked, first locked, second locked.
// - code 4 both references missing; code 5 that and second lock.
// - code 6 gives reference B chosen flag, valid in automatic mode.
// - codes 7..12 give presence flags A, B, test, osc, feedback, ref.
// - code 13 reserved; 14 both references present; 15 all but test.
// - codes 16..19 give divided-by-two loop signals; 20..23 ground.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "csrm_defines.svh"
module csrm_status_mux #(
  parameter int ADDR_W = 14
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire csrm_pkg::csrm_word_type wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output csrm_pkg::csrm_resp_type bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output csrm_pkg::csrm_word_type rdata,
  output csrm_pkg::csrm_resp_type rresp,
  // Clock presence flags, one is present
  input wire logic refAPresent,
  input wire logic refBPresent,
  input wire logic testRefPresent,
  input wire logic oscClockPresent,
  input wire logic firstLoopFbPresent,
  input wire logic secondLoopRefPresent,
  // Loop and reference state
  input wire logic firstLoopLocked,
  input wire logic secondLoopLocked,
  input wire logic holdoverActive,
  input wire logic refBChosen,
  input wire logic vcoCalBusy,
  // Raw loop signals for divided monitoring
  input wire logic firstLoopFbClk,
  input wire logic pfdDown,
  input wire logic firstLoopRefClk,
  input wire logic pfdUp,
  // Status output 0
  output logic statusOut0
);
  import csrm_pkg::*;

  // Register decode, shared by the read and write paths
  function automatic csrm_reg_type decodeReg(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    if (idx == (ADDR_W-2)'(`CSRM_IDX_CLK_LOCK)) begin
      decodeReg = CSRM_REG_CLK_LOCK;
    end else if (idx == (ADDR_W-2)'(`CSRM_IDX_HOLD_CAL)) begin
      decodeReg = CSRM_REG_HOLD_CAL;
    end else if (idx == (ADDR_W-2)'(`CSRM_IDX_OUT0_SEL)) begin
      decodeReg = CSRM_REG_OUT0_SEL;
    end else begin
      decodeReg = CSRM_REG_NONE;
    end
  endfunction : decodeReg

  // Input synchronisation
  logic [`CSRM_IN_COUNT-1:0] rawIn;
  logic [`CSRM_IN_COUNT-1:0] syncIn;

  assign rawIn = {pfdUp, firstLoopRefClk, pfdDown, firstLoopFbClk,
                  vcoCalBusy, refBChosen, holdoverActive,
                  secondLoopLocked, firstLoopLocked,
                  secondLoopRefPresent, firstLoopFbPresent,
                  oscClockPresent, testRefPresent, refBPresent,
                  refAPresent};

  csrm_sync #(
    .WIDTH(`CSRM_IN_COUNT)
  ) inSync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  wire sRefA = syncIn[0];
  wire sRefB = syncIn[1];
  wire sTestRef = syncIn[2];
  wire sOsc = syncIn[3];
  wire sFbOk = syncIn[4];
  wire sRef2Ok = syncIn[5];
  wire sLock1 = syncIn[6];
  wire sLock2 = syncIn[7];
  wire sHold = syncIn[8];
  wire sChoseB = syncIn[9];
  wire sCal = syncIn[10];
  wire [3:0] sRaw = syncIn[14:11];

  // Divide-by-two of the raw loop signals
  logic [3:0] rawPrevReg;
  logic [3:0] halfReg;
  logic [3:0] halfNext;
  wire [3:0] rawRise = sRaw & ~rawPrevReg;

  // Pulses shorter than one clock can be lost; the monitor is coarse
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gHalf
      assign halfNext[gi] = halfReg[gi] ^ rawRise[gi];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      rawPrevReg <= 4'h0;
      halfReg <= 4'h0;
    end else if (ce) begin
      rawPrevReg <= sRaw;
      halfReg <= halfNext;
    end
  end

  // Live readback values
  logic [7:0] clkLockView;
  logic [7:0] holdCalView;

  assign clkLockView = {sRef2Ok, sFbOk, sOsc, sTestRef, sRefB, sRefA,
                        sLock2, sLock1};
  assign holdCalView = {4'h0, sHold, sChoseB, 1'b0, sCal};

  // Status output 0 selection
  logic [`CSRM_SEL_MSB:0] selReg;
  logic [`CSRM_SEL_COUNT-1:0] muxSrc;
  wire bothMissing = ~sRefA & ~sRefB;
  wire selLegal = (selReg <= `CSRM_SEL_LAST) &&
                  (selReg != `CSRM_SEL_RESERVED);

  assign muxSrc[3:0] = {sLock2, sLock1, sLock1 & sLock2, 1'b0};
  assign muxSrc[5:4] = {bothMissing & sLock2, bothMissing};
  assign muxSrc[6] = sChoseB;
  assign muxSrc[12:7] = {sRef2Ok, sFbOk, sOsc, sTestRef, sRefB, sRefA};
  assign muxSrc[15:13] = {sRefA & sRefB & sOsc & sFbOk & sRef2Ok,
                          sRefA & sRefB, 1'b0};
  assign muxSrc[19:16] = halfReg;
  assign muxSrc[23:20] = 4'h0;

  wire muxOut = selLegal ? muxSrc[selReg[4:0]] : 1'b0;

  always_ff @(posedge clk) begin
    if (srst) begin
      statusOut0 <= 1'b0;
    end else if (ce) begin
      statusOut0 <= muxOut;
    end
  end

  // Write channel
  logic awHeldReg;
  logic wHeldReg;
  logic [ADDR_W-1:0] awAddrReg;
  logic [7:0] wByteReg;
  logic wLaneReg;
  wire awTake = awvalid & awready;
  wire wTake = wvalid & wready;
  wire doWrite = awHeldReg & wHeldReg & ~bvalid;
  wire bDone = bvalid & bready;
  csrm_reg_type wrTarget;

  assign wrTarget = decodeReg(awAddrReg);

  // only the select register accepts data
  wire selWrite = doWrite & (wrTarget == CSRM_REG_OUT0_SEL) & wLaneReg;
  csrm_resp_type wrResp;
  assign wrResp = (wrTarget == CSRM_REG_NONE) ? CSRM_RESP_DECERR :
                  CSRM_RESP_OKAY;

  always_ff @(posedge clk) begin
    if (srst) begin
      awready <= 1'b1;
      awHeldReg <= 1'b0;
      awAddrReg <= '0;
    end else if (ce) begin
      if (awTake) begin
        awready <= 1'b0;
        awHeldReg <= 1'b1;
        awAddrReg <= awaddr;
      end else if (doWrite) begin
        awHeldReg <= 1'b0;
      end else if (bDone) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wready <= 1'b1;
      wHeldReg <= 1'b0;
      wByteReg <= 8'h00;
      wLaneReg <= 1'b0;
    end else if (ce) begin
      if (wTake) begin
        wready <= 1'b0;
        wHeldReg <= 1'b1;
        wByteReg <= wdata[7:0];
        wLaneReg <= wstrb[0];
      end else if (doWrite) begin
        wHeldReg <= 1'b0;
      end else if (bDone) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp <= CSRM_RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= wrResp;
      end else if (bDone) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      selReg <= `CSRM_SEL_RESET;
    end else if (ce && selWrite) begin
      selReg <= wByteReg[`CSRM_SEL_MSB:0];
    end
  end

  // Read channel
  wire arTake = arvalid & arready;
  wire rDone = rvalid & rready;
  csrm_reg_type rdTarget;
  csrm_word_type rdWord;

  assign rdTarget = decodeReg(araddr);
  // readback sampled live at the read
  assign rdWord = (rdTarget == CSRM_REG_CLK_LOCK) ? {24'h0, clkLockView} :
                  (rdTarget == CSRM_REG_HOLD_CAL) ? {24'h0, holdCalView} :
                  (rdTarget == CSRM_REG_OUT0_SEL) ? {26'h0, selReg} :
                  32'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= CSRM_RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdWord;
        rresp <= (rdTarget == CSRM_REG_NONE) ? CSRM_RESP_DECERR :
                 CSRM_RESP_OKAY;
      end else if (rDone) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : csrm_status_mux

/* File: tb/csrm_status_mux_sva.sv */
// Bus handshake and status output checks for the readback block.
// Bound to the block top; sees its ports only; bus idle while ce is low.
`timescale 1ns/1ps
module csrm_status_mux_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Write channels
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire csrm_pkg::csrm_resp_type bresp,
  // Read channels
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire csrm_pkg::csrm_word_type rdata,
  // Status output
  input wire logic statusOut0
);
  import csrm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rlat;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_rfree;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_rfree: assert property (p_rfree) else $error("read not closed");
  property p_blat;
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write resp moved");
  property p_bfree;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_bfree: assert property (p_bfree) else $error("write not closed");
  // Own disable: the reset itself is the cause here
  property p_rst;
    disable iff (1'h0) srst |=> !statusOut0 && !rvalid && !bvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_rdat;
    rvalid |-> rdata[31:8] == 24'h0;
  endproperty
  a_rdat: assert property (p_rdat) else $error("upper bits set");
endmodule : csrm_status_mux_sva

/* File: tb/csrm_status_mux_tb.sv */
// Directed bench for the readback block over AXI4-Lite.
// Assumes design files and the defines header on the include path.
`timescale 1ns/1ps
`include "csrm_defines.svh"
module csrm_status_mux_tb;
  import csrm_pkg::*;
  localparam logic [13:0] A0 = {`CSRM_IDX_CLK_LOCK, 2'h0};
  localparam logic [13:0] A1 = {`CSRM_IDX_HOLD_CAL, 2'h0};
  localparam logic [13:0] AS = {`CSRM_IDX_OUT0_SEL, 2'h0};
  localparam csrm_resp_type OK = CSRM_RESP_OKAY;
  logic clk = 1'h0, srst = 1'h1, ce = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, statusOut0;
  logic [13:0] awaddr = 14'h0, araddr = 14'h0;
  logic [3:0] wstrb = 4'h0, raw = 4'h0;
  logic [2:0] prot = 3'h0;
  logic [10:0] st = 11'h0;
  logic [10:0] pats [6] = '{11'h0, 11'h7ff, 11'h1ef, 11'h202, 11'h555, 11'haa};
  csrm_word_type wdata = 32'h0, rdata;
  csrm_resp_type bresp, rresp;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #2.5 clk = ~clk;
  csrm_status_mux u_dut (
    .clk, .srst, .ce, .awvalid, .awready, .awaddr, .awprot(prot),
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(prot), .rvalid, .rready,
    .rdata, .rresp, .refAPresent(st[2]), .refBPresent(st[3]),
    .testRefPresent(st[4]), .oscClockPresent(st[5]),
    .firstLoopFbPresent(st[6]), .secondLoopRefPresent(st[7]),
    .firstLoopLocked(st[0]), .secondLoopLocked(st[1]),
    .holdoverActive(st[8]), .refBChosen(st[9]), .vcoCalBusy(st[10]),
    .firstLoopFbClk(raw[0]), .pfdDown(raw[1]),
    .firstLoopRefClk(raw[2]), .pfdUp(raw[3]), .statusOut0
  );
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input csrm_word_type g, input csrm_word_type e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [13:0] a, input csrm_word_type d,
      input logic [3:0] s, input csrm_resp_type r);
    logic ga, gw;
    ga = 1'h0;
    gw = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        ga = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        gw = 1'h1;
        wvalid <= 1'h0;
      end
    end
    // Late ready makes the slave hold its answer
    do @(posedge clk); while (bvalid !== 1'h1);
    bready <= 1'h1;
    @(posedge clk);
    chk(32'(bresp), 32'(r));
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [13:0] a, input csrm_word_type e,
      input csrm_resp_type r);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    rready <= 1'h1;
    @(posedge clk);
    chk(rdata, e);
    chk(32'(rresp), 32'(r));
    rready <= 1'h0;
  endtask : rd
  function automatic csrm_word_type mx(int c, logic [10:0] s);
    logic b;
    case (c)
      1: b = s[0] & s[1];
      2: b = s[0];
      3: b = s[1];
      4: b = !s[2] & !s[3];
      5: b = !s[2] & !s[3] & s[1];
      6: b = s[9];
      7, 8, 9, 10, 11, 12: b = s[c - 5];
      14: b = s[2] & s[3];
      15: b = s[2] & s[3] & s[5] & s[6] & s[7];
      default: b = 1'h0;
    endcase
    return {31'h0, b};
  endfunction : mx
  task automatic t_regs;
    logic [10:0] p;
    rd(AS, 32'h0, OK);
    for (int i = 3; i < 5; i++) begin
      p = pats[i];
      st <= p;
      repeat (4) @(posedge clk);
      wr(A0, 32'hff, 4'hf, OK);
      wr(A1, 32'hff, 4'hf, OK);
      rd(A0, {24'h0, p[7:0]}, OK);
      rd(A1, {28'h0, p[8], p[9], 1'h0, p[10]}, OK);
    end
    wr(AS, 32'hff, 4'hf, OK);
    rd(AS, 32'h3f, OK);
    wr(AS, 32'h1, 4'he, OK);
    rd(AS, 32'h3f, OK);
    wr(14'h4, 32'h1, 4'hf, CSRM_RESP_DECERR);
    rd(14'h4, 32'h0, CSRM_RESP_DECERR);
    $display("test regs done");
  endtask : t_regs
  task automatic t_mux;
    csrm_word_type o;
    for (int c = 0; c < 64; c++) begin
      wr(AS, 32'(c), 4'h1, OK);
      foreach (pats[i]) begin
        st <= pats[i];
        repeat (4) @(posedge clk);
        o = 32'(statusOut0);
        // Divided codes are judged in t_div
        if (c < 16 || c > 19)
          chk(o, mx(c, pats[i]));
      end
    end
    $display("test mux done");
  endtask : t_mux
  task automatic t_div;
    logic e;
    for (int k = 0; k < 4; k++) begin
      wr(AS, 32'(16 + k), 4'h1, OK);
      repeat (4) @(posedge clk);
      // Raw pins idle until now, so every divider starts at zero
      e = 1'h0;
      chk(32'(statusOut0), 32'(e));
      repeat (2) begin
        raw[k] <= 1'h1;
        repeat (4) @(posedge clk);
        raw[k] <= 1'h0;
        repeat (4) @(posedge clk);
        e = !e;
        chk(32'(statusOut0), 32'(e));
      end
    end
    $display("test div done");
  endtask : t_div
  task automatic t_ce;
    wr(AS, 32'h7, 4'h1, OK);
    st <= 11'h7ff;
    repeat (4) @(posedge clk);
    ce <= 1'h0;
    st <= 11'h0;
    repeat (6) @(posedge clk);
    // Frozen synchronisers keep the old presence level
    chk(32'(statusOut0), 32'h1);
    ce <= 1'h1;
    repeat (4) @(posedge clk);
    chk(32'(statusOut0), 32'h0);
    $display("test enable done");
  endtask : t_ce
  task automatic t_rst;
    wr(AS, 32'h7, 4'h1, OK);
    st <= 11'h7ff;
    repeat (4) @(posedge clk);
    chk(32'(statusOut0), 32'h1);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    chk(32'(statusOut0), 32'h0);
    rd(AS, 32'h0, OK);
    $display("test reset done");
  endtask : t_rst
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_mux();
    t_div();
    t_ce();
    t_rst();
    summarize();
  end
endmodule : csrm_status_mux_tb
bind csrm_status_mux csrm_status_mux_sva u_sva (
  .clk, .srst, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .statusOut0
);
